//--- hw/serial_ctrl.sv
// control, trigger select and interrupt masking for an asynchronous serial port
// Notes on behaviour
// - reset clears all control bits except transmit and receive enables, which read 1
// - the port runs only while module enable, control bit 0, is set
// - disabling mid-character lets that character finish first
// - control bit 9 enables receive; clear means no new characters accepted
// - control bit 8 enables transmit; clear means no new characters started
// - control bit 7 loops the transmit line into the receive path
// - reserved bits read as zero here, except raw status bits 3:0, which read 0xf; software keeps them unchanged
// - level interrupts fire when the fill level crosses the trigger point
// - receive at one half fires as the character passing half full arrives
// - receive trigger bits 5:3, reset 2, above 1/8..7/8; 5-7 reserved
// - transmit trigger bits 2:0, reset 2, at most 1/8..7/8; 5-7 reserved
// - trigger selects decide when transmit and receive raw flags set
// - reading the mask register returns the held mask bits
// - mask bit 1 passes the raw interrupt on; 0 blocks it
// - mask bits overrun 10 down to receive 4, all reset to 0
// - masked status is raw and mask; writes to status views do nothing
// - writing 1 to the clear register clears that source; 0 does nothing
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
module serial_ctrl #(
  parameter int fifo_depth = 16,
  parameter int level_width = 5
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  output logic [31:0] reg_rdata_o,
  // fifo fill levels from the data path
  input wire logic [level_width-1:0] tx_fifo_level_i,
  input wire logic [level_width-1:0] rx_fifo_level_i,
  // character progress from the data path
  input wire logic tx_char_busy_i,
  input wire logic rx_char_busy_i,
  // error and time-out events from the data path, one-cycle pulses
  input wire logic rx_timeout_event_i,
  input wire logic framing_error_event_i,
  input wire logic parity_error_event_i,
  input wire logic break_error_event_i,
  input wire logic overrun_error_event_i,
  // serial lines
  input wire logic serial_in_line_i,
  input wire logic serial_out_line_i,
  output logic serial_rx_path_o,
  // enables to the data path
  output logic transmit_run_o,
  output logic receive_run_o,
  output logic loopback_o,
  // interrupt to the interrupt controller
  output logic irq_o
);
  // control state
  logic module_enable_reg;
  logic transmit_section_enable_reg;
  logic receive_section_enable_reg;
  logic loopback_enable_reg;
  logic [2:0] transmit_trigger_select_reg;
  logic [2:0] receive_trigger_select_reg;
  logic [serial_ctrl_pkg::irq_count-1:0] irq_mask_reg;
  logic [serial_ctrl_pkg::irq_count-1:0] raw_irq_status_reg;
  logic [serial_ctrl_pkg::irq_count-1:0] raw_irq_status_next;
  logic [serial_ctrl_pkg::irq_count-1:0] masked_irq_status;
  logic [serial_ctrl_pkg::irq_count-1:0] irq_event;
  logic [serial_ctrl_pkg::irq_count-1:0] irq_clear;
  logic [31:0] rdata_next;
  logic [31:0] rdata_reg;
  // register words as software sees them
  logic [31:0] ctl_word;
  logic [31:0] ifls_word;
  logic [31:0] raw_word;
  // line synchroniser
  logic serial_in_meta_reg;
  logic serial_in_sync_reg;
  // enable gating
  logic tx_allowed;
  logic rx_allowed;
  logic transmit_run_reg;
  logic receive_run_reg;
  // trigger thresholds
  logic [level_width-1:0] tx_threshold;
  logic [level_width-1:0] rx_threshold;
  logic tx_crossed;
  logic rx_crossed;
  logic wr_ctl;
  logic wr_ifls;
  logic wr_mask;
  logic wr_clear;

  // address decode; status views ignore writes
  assign wr_ctl = reg_write_i && (reg_addr_i == serial_ctrl_pkg::port_control_offset);
  assign wr_ifls = reg_write_i && (reg_addr_i == serial_ctrl_pkg::fifo_irq_level_select_offset);
  assign wr_mask = reg_write_i && (reg_addr_i == serial_ctrl_pkg::irq_mask_offset);
  assign wr_clear = reg_write_i && (reg_addr_i == serial_ctrl_pkg::irq_clear_offset);

  // module enable, off after reset so nothing runs until software asks
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      module_enable_reg <= 1'b0;
    end else if (wr_ctl) begin
      module_enable_reg <= reg_wdata_i[serial_ctrl_pkg::module_enable_bit];
    end
  end

  // loopback enable, off after reset
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      loopback_enable_reg <= 1'b0;
    end else if (wr_ctl) begin
      loopback_enable_reg <= reg_wdata_i[serial_ctrl_pkg::loopback_enable_bit];
    end
  end

  // transmit section enable, set after reset
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      transmit_section_enable_reg <= 1'b1;
    end else if (wr_ctl) begin
      transmit_section_enable_reg <= reg_wdata_i[serial_ctrl_pkg::transmit_section_enable_bit];
    end
  end

  // receive section enable, set after reset
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      receive_section_enable_reg <= 1'b1;
    end else if (wr_ctl) begin
      receive_section_enable_reg <= reg_wdata_i[serial_ctrl_pkg::receive_section_enable_bit];
    end
  end

  // transmit trigger select; reserved codes are stored but treated as 7/8
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      transmit_trigger_select_reg <= serial_ctrl_pkg::trigger_reset;
    end else if (wr_ifls) begin
      transmit_trigger_select_reg <= reg_wdata_i[serial_ctrl_pkg::transmit_trigger_lsb +: 3];
    end
  end

  // receive trigger select; read back exactly as written, even reserved codes
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      receive_trigger_select_reg <= serial_ctrl_pkg::trigger_reset;
    end else if (wr_ifls) begin
      receive_trigger_select_reg <= reg_wdata_i[serial_ctrl_pkg::receive_trigger_lsb +: 3];
    end
  end

  // interrupt mask register
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      irq_mask_reg <= '0;
    end else if (wr_mask) begin
      irq_mask_reg <= reg_wdata_i[serial_ctrl_pkg::irq_lsb +: serial_ctrl_pkg::irq_count];
    end
  end

  // threshold in eighths of depth: code 0 is 1/8, code 4 is 7/8
  function automatic logic [level_width-1:0] threshold_of(input logic [2:0] code);
    logic [2:0] eff;
    int num;
    eff = (code > serial_ctrl_pkg::trigger_max_code) ? serial_ctrl_pkg::trigger_max_code : code;
    case (eff)
      3'h0: num = 1;
      3'h1: num = 2;
      3'h2: num = 4;
      3'h3: num = 6;
      default: num = 7;
    endcase
    threshold_of = level_width'((fifo_depth * num) / serial_ctrl_pkg::eighths);
  endfunction

  // trigger points from the select fields
  assign tx_threshold = threshold_of(transmit_trigger_select_reg);
  assign rx_threshold = level_width'(threshold_of(receive_trigger_select_reg) + 1'b1);

  // transmit level crossing, counted downward
  level_crossing #(
    .level_width(level_width)
  ) tx_level (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .level_i(tx_fifo_level_i),
    .threshold_i(tx_threshold),
    .at_most_i(1'b1),
    .crossed_o(tx_crossed)
  );

  // receive level crossing; past half means the ninth of sixteen
  level_crossing #(
    .level_width(level_width)
  ) rx_level (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .level_i(rx_fifo_level_i),
    .threshold_i(rx_threshold),
    .at_most_i(1'b0),
    .crossed_o(rx_crossed)
  );

  // collect the source events into status bit order
  always_comb begin
    irq_event = '0;
    irq_event[serial_ctrl_pkg::irq_receive] = rx_crossed;
    irq_event[serial_ctrl_pkg::irq_transmit] = tx_crossed;
    irq_event[serial_ctrl_pkg::irq_timeout] = rx_timeout_event_i;
    irq_event[serial_ctrl_pkg::irq_framing] = framing_error_event_i;
    irq_event[serial_ctrl_pkg::irq_parity] = parity_error_event_i;
    irq_event[serial_ctrl_pkg::irq_break] = break_error_event_i;
    irq_event[serial_ctrl_pkg::irq_overrun] = overrun_error_event_i;
  end

  // write-one clear; a new event in the same cycle wins so none is lost
  assign irq_clear = wr_clear ? reg_wdata_i[serial_ctrl_pkg::irq_lsb +: serial_ctrl_pkg::irq_count] : '0;
  assign raw_irq_status_next = (raw_irq_status_reg & ~irq_clear) | irq_event;

  // sticky raw status
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      raw_irq_status_reg <= '0;
    end else begin
      raw_irq_status_reg <= raw_irq_status_next;
    end
  end

  // masking and the single interrupt line
  assign masked_irq_status = raw_irq_status_reg & irq_mask_reg;
  assign irq_o = |masked_irq_status;

  // control word; reserved positions read zero so software sees a clean value
  always_comb begin
    ctl_word = '0;
    ctl_word[serial_ctrl_pkg::module_enable_bit] = module_enable_reg;
    ctl_word[serial_ctrl_pkg::loopback_enable_bit] = loopback_enable_reg;
    ctl_word[serial_ctrl_pkg::transmit_section_enable_bit] = transmit_section_enable_reg;
    ctl_word[serial_ctrl_pkg::receive_section_enable_bit] = receive_section_enable_reg;
  end

  // trigger select word
  always_comb begin
    ifls_word = '0;
    ifls_word[serial_ctrl_pkg::transmit_trigger_lsb +: 3] = transmit_trigger_select_reg;
    ifls_word[serial_ctrl_pkg::receive_trigger_lsb +: 3] = receive_trigger_select_reg;
  end

  // raw status word; the low nibble is a fixed pattern, not state
  always_comb begin
    raw_word = '0;
    raw_word[3:0] = serial_ctrl_pkg::raw_reserved_value;
    raw_word[serial_ctrl_pkg::irq_lsb +: serial_ctrl_pkg::irq_count] = raw_irq_status_reg;
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    rdata_next = '0;
    case (reg_addr_i)
      serial_ctrl_pkg::port_control_offset: begin
        rdata_next = ctl_word;
      end
      serial_ctrl_pkg::fifo_irq_level_select_offset: begin
        rdata_next = ifls_word;
      end
      serial_ctrl_pkg::irq_mask_offset: begin
        rdata_next[serial_ctrl_pkg::irq_lsb +: serial_ctrl_pkg::irq_count] = irq_mask_reg;
      end
      serial_ctrl_pkg::raw_irq_status_offset: begin
        rdata_next = raw_word;
      end
      serial_ctrl_pkg::masked_irq_status_offset: begin
        rdata_next[serial_ctrl_pkg::irq_lsb +: serial_ctrl_pkg::irq_count] = masked_irq_status;
      end
      default: begin
        rdata_next = '0;
      end
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_reg <= '0;
    end else if (reg_read_i) begin
      rdata_reg <= rdata_next;
    end else begin
      rdata_reg <= '0;
    end
  end
  assign reg_rdata_o = rdata_reg;

  // first synchroniser flop; resets to the idle high line level
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      serial_in_meta_reg <= 1'b1;
    end else begin
      serial_in_meta_reg <= serial_in_line_i;
    end
  end

  // second synchroniser flop; the only reader of the first
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      serial_in_sync_reg <= 1'b1;
    end else begin
      serial_in_sync_reg <= serial_in_meta_reg;
    end
  end

  // loopback feeds the transmit line to the receiver instead of the pin
  assign serial_rx_path_o = loopback_enable_reg ? serial_out_line_i : serial_in_sync_reg;

  // new characters need module and section enables
  assign tx_allowed = module_enable_reg & transmit_section_enable_reg;
  assign rx_allowed = module_enable_reg & receive_section_enable_reg;

  // transmit run holds while a character is busy, so a disable waits for its end
  // limitation: a busy flag stuck high keeps the section running
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      transmit_run_reg <= 1'b0;
    end else begin
      transmit_run_reg <= tx_allowed | (transmit_run_reg & tx_char_busy_i);
    end
  end

  // receive run, same hold as transmit
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      receive_run_reg <= 1'b0;
    end else begin
      receive_run_reg <= rx_allowed | (receive_run_reg & rx_char_busy_i);
    end
  end

  assign transmit_run_o = transmit_run_reg;
  assign receive_run_o = receive_run_reg;
  assign loopback_o = loopback_enable_reg;
endmodule

//--- hw/serial_ctrl_pkg.sv
// constants for the serial port control and interrupt configuration block
package serial_ctrl_pkg;
  // register byte offsets
  localparam logic [7:0] port_control_offset = 8'h30;
  localparam logic [7:0] fifo_irq_level_select_offset = 8'h34;
  localparam logic [7:0] irq_mask_offset = 8'h38;
  localparam logic [7:0] raw_irq_status_offset = 8'h3c;
  localparam logic [7:0] masked_irq_status_offset = 8'h40;
  localparam logic [7:0] irq_clear_offset = 8'h44;
  // port_control fields
  localparam int module_enable_bit = 0;
  localparam int loopback_enable_bit = 7;
  localparam int transmit_section_enable_bit = 8;
  localparam int receive_section_enable_bit = 9;
  // fifo_irq_level_select fields
  localparam int transmit_trigger_lsb = 0;
  localparam int receive_trigger_lsb = 3;
  localparam int trigger_width = 3;
  localparam logic [2:0] trigger_reset = 3'h2;
  localparam logic [2:0] trigger_max_code = 3'h4;
  // interrupt source field, bits 10:4
  localparam int irq_lsb = 4;
  localparam int irq_count = 7;
  localparam int irq_receive = 0;
  localparam int irq_transmit = 1;
  localparam int irq_timeout = 2;
  localparam int irq_framing = 3;
  localparam int irq_parity = 4;
  localparam int irq_break = 5;
  localparam int irq_overrun = 6;
  // reserved low bits of raw status read as this value
  localparam logic [3:0] raw_reserved_value = 4'hf;
  // eighths of the fifo depth
  localparam int eighths = 8;
endpackage

//--- hw/level_crossing.sv
// edge detector that flags a fifo fill level passing a trigger point
`timescale 1ns/1ps
module level_crossing #(
  parameter int level_width = 5
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // level and threshold
  input wire logic [level_width-1:0] level_i,
  input wire logic [level_width-1:0] threshold_i,
  input wire logic at_most_i,
  // crossing event
  output logic crossed_o
);
  logic beyond;
  logic beyond_reg;

  // at-most compares downward for transmit, at-least upward for receive
  assign beyond = at_most_i ? (level_i <= threshold_i) : (level_i >= threshold_i);

  // previous comparison, so only a transition counts
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      beyond_reg <= 1'b1;
    end else begin
      beyond_reg <= beyond;
    end
  end

  // pulse on the cycle the level passes the trigger point
  assign crossed_o = beyond & ~beyond_reg;
endmodule

//--- verif/serial_ctrl_chk.sv
// port-level assertions for the serial port control block
`timescale 1ns/1ps
module serial_ctrl_chk (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  input wire logic [31:0] reg_rdata_o,
  // data path side
  input wire logic tx_char_busy_i,
  input wire logic rx_char_busy_i,
  input wire logic serial_out_line_i,
  input wire logic serial_rx_path_o,
  input wire logic transmit_run_o,
  input wire logic receive_run_o,
  input wire logic loopback_o,
  input wire logic irq_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  // read data, enables, loopback and interrupt move only for a cause at the inputs
  chk_rdata_idle: assert property (!$past(reg_read_i) |-> reg_rdata_o == 32'h0)
    else $error("read data outside read cycle");
  chk_loop_path: assert property (loopback_o |-> serial_rx_path_o == serial_out_line_i)
    else $error("loopback path not routed");
  chk_loop_write: assert property ($changed(loopback_o) |-> $past(reg_write_i && reg_addr_i == 8'h30))
    else $error("loopback changed without control write");
  chk_tx_hold: assert property (transmit_run_o && tx_char_busy_i |=> transmit_run_o)
    else $error("transmit stopped mid character");
  chk_rx_hold: assert property (receive_run_o && rx_char_busy_i |=> receive_run_o)
    else $error("receive stopped mid character");
  chk_tx_rise: assert property ($rose(transmit_run_o) |-> $past(reg_write_i && reg_addr_i == 8'h30, 2))
    else $error("transmit started without control write");
  chk_rx_rise: assert property ($rose(receive_run_o) |-> $past(reg_write_i && reg_addr_i == 8'h30, 2))
    else $error("receive started without control write");
  chk_tx_drop: assert property ($fell(transmit_run_o) |-> !$past(tx_char_busy_i))
    else $error("transmit dropped while busy");
  chk_irq_fall: assert property ($fell(irq_o) |-> $past(reg_write_i))
    else $error("interrupt fell without a write");
endmodule
bind serial_ctrl serial_ctrl_chk i_chk (.clk_sys_i, .reset_i, .reg_addr_i, .reg_write_i, .reg_read_i,
  .reg_rdata_o, .tx_char_busy_i, .rx_char_busy_i, .serial_out_line_i, .serial_rx_path_o, .transmit_run_o,
  .receive_run_o, .loopback_o, .irq_o);

//--- verif/serial_far_model.sv
// far side data path: one ten-cycle character per start request
`timescale 1ns/1ps
module serial_far_model (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // start request and enables from the block
  input wire logic start_i,
  input wire logic tx_run_i,
  input wire logic rx_run_i,
  // character progress and lines
  output logic tx_busy_o,
  output logic rx_busy_o,
  output logic tx_line_o,
  output logic rx_line_o
);
  logic [3:0] cnt_reg;
  // a section that is not running starts no new character
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      cnt_reg <= 4'h0;
      tx_busy_o <= 1'b0;
      rx_busy_o <= 1'b0;
    end else if (cnt_reg != 4'h0) begin
      cnt_reg <= cnt_reg - 4'h1;
      if (cnt_reg == 4'h1) begin
        tx_busy_o <= 1'b0;
        rx_busy_o <= 1'b0;
      end
    end else if (start_i) begin
      cnt_reg <= 4'ha;
      tx_busy_o <= tx_run_i;
      rx_busy_o <= rx_run_i;
    end
  end
  // lines idle high; opposite toggling so loopback is told apart
  assign tx_line_o = tx_busy_o ? cnt_reg[0] : 1'b1;
  assign rx_line_o = rx_busy_o ? ~cnt_reg[0] : 1'b1;
endmodule

//--- verif/tb.sv
// self-checking bench for the serial port control block
`timescale 1ns/1ps
module tb;
  typedef struct {
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] e;
  } row_type;
  localparam int depth = 16;
  logic clk_sys_i = 1'b0;
  logic reset_i = 1'b1;
  logic [7:0] addr = 8'h0;
  logic [31:0] wdata = 32'h0;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic [4:0] tx_lvl = 5'h0;
  logic [4:0] rx_lvl = 5'h0;
  logic [4:0] ev = 5'h0;
  logic start = 1'b0;
  logic [31:0] rdata;
  logic tx_busy, rx_busy, tx_line, rx_line, rx_path, tx_run, rx_run, loop, irq;
  int err_total = 0;
  int tests_run = 0;
  int cyc = 0;
  int thr;
  int k;
  int frac[5] = '{1, 2, 4, 6, 7};
  // write then read back; reserved codes and bits, status views, unmapped
  row_type rows[6] = '{'{8'h34, 32'hffffffff, 32'h3f}, '{8'h38, 32'hffffffff, 32'h7f0},
    '{8'h3c, 32'hffffffff, 32'hf}, '{8'h40, 32'hffffffff, 32'h0}, '{8'h50, 32'hffffffff, 32'h0},
    '{8'h30, 32'h380, 32'h380}};
  serial_far_model i_far (.clk_sys_i, .reset_i, .start_i(start), .tx_run_i(tx_run), .rx_run_i(rx_run),
    .tx_busy_o(tx_busy), .rx_busy_o(rx_busy), .tx_line_o(tx_line), .rx_line_o(rx_line));
  serial_ctrl #(.fifo_depth(depth), .level_width(5)) i_dut (.clk_sys_i, .reset_i, .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_write_i(wr_s), .reg_read_i(rd_s), .reg_rdata_o(rdata), .tx_fifo_level_i(tx_lvl),
    .rx_fifo_level_i(rx_lvl), .tx_char_busy_i(tx_busy), .rx_char_busy_i(rx_busy), .rx_timeout_event_i(ev[0]),
    .framing_error_event_i(ev[1]), .parity_error_event_i(ev[2]), .break_error_event_i(ev[3]),
    .overrun_error_event_i(ev[4]), .serial_in_line_i(rx_line), .serial_out_line_i(tx_line),
    .serial_rx_path_o(rx_path), .transmit_run_o(tx_run), .receive_run_o(rx_run), .loopback_o(loop), .irq_o(irq));
  task automatic chk32(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic chk1(input string n, input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s exp %b got %b", n, e, g);
    end
  endtask
  // bus cycles keep a quiet edge after each strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk_sys_i);
    wr_s <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys_i);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk_sys_i);
    rd_s <= 1'b0;
    #1 chk32("rdata", e, rdata);
  endtask
  task automatic pulse(input int i);
    @(posedge clk_sys_i);
    ev[i] <= 1'b1;
    @(posedge clk_sys_i);
    ev[i] <= 1'b0;
  endtask
  task automatic lvl(input int t, input int r);
    @(posedge clk_sys_i);
    tx_lvl <= 5'(t);
    rx_lvl <= 5'(r);
    @(posedge clk_sys_i);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    forever #20 clk_sys_i = ~clk_sys_i;
  end
  // hang guard, far above the few hundred cycles of the run
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      err_total++;
      end_sim();
    end
  end
  initial begin
    repeat (3) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].e);
    end
    $display("test rows done");
    // second reset in mid-run, then reset values
    @(posedge clk_sys_i);
    reset_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    rd(8'h30, 32'h300);
    rd(8'h34, 32'h12);
    rd(8'h38, 32'h0);
    rd(8'h3c, 32'hf);
    chk1("loop", 1'b0, loop);
    chk1("rx_path", 1'b1, rx_path);
    $display("test reset done");
    // enable with loopback, start a character, disable mid-character
    wr(8'h30, 32'h381);
    @(posedge clk_sys_i);
    start <= 1'b1;
    @(posedge clk_sys_i);
    start <= 1'b0;
    #1 chk1("loop", tx_line, rx_path);
    wr(8'h30, 32'h380);
    #1 chk1("tx_run", 1'b1, tx_run);
    chk1("rx_run", 1'b1, rx_run);
    for (k = 0; k < 20 && tx_busy === 1'b1; k++) @(posedge clk_sys_i);
    @(posedge clk_sys_i);
    #1 chk1("tx_run", 1'b0, tx_run);
    chk1("rx_run", 1'b0, rx_run);
    $display("test enables done");
    // each time-out and error source raised, seen, cleared; then masked out
    wr(8'h38, 32'h7f0);
    for (k = 0; k < 5; k++) begin
      pulse(k);
      #1 chk1("irq", 1'b1, irq);
      rd(8'h3c, 32'hf | (32'h40 << k));
      rd(8'h40, 32'h40 << k);
      wr(8'h44, 32'h40 << k);
      #1 chk1("irq", 1'b0, irq);
    end
    wr(8'h38, 32'h0);
    pulse(4);
    #1 chk1("irq", 1'b0, irq);
    wr(8'h38, 32'h400);
    #1 chk1("irq", 1'b1, irq);
    wr(8'h44, 32'h0);
    #1 chk1("irq", 1'b1, irq);
    wr(8'h44, 32'h400);
    #1 chk1("irq", 1'b0, irq);
    $display("test interrupts done");
    // trigger codes 0 to 4: crossing sets the flag, sitting past it does not
    wr(8'h38, 32'h30);
    for (k = 0; k < 5; k++) begin
      thr = depth * frac[k] / 8;
      wr(8'h34, 32'(k * 9));
      lvl(thr + 1, 0);
      wr(8'h44, 32'h30);
      lvl(thr + 1, thr);
      rd(8'h3c, 32'hf);
      lvl(thr, thr + 1);
      rd(8'h3c, 32'h3f);
      #1 chk1("irq", 1'b1, irq);
      wr(8'h44, 32'h30);
      lvl(thr, thr + 1);
      rd(8'h3c, 32'hf);
    end
    $display("test levels done");
    end_sim();
  end
endmodule
